// ===== inc/alu_pkg.sv
package alu_pkg;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int          DATA_W      = 32;
  localparam int          AMT_W       = 8;
  localparam int          TWELVE_BIT_IMMEDIATE_W     = 12;
  localparam int          SHIMM_W     = 6;
  localparam int          CLZ_W       = 6;
  localparam int          MSB         = DATA_W - 1;
  localparam logic [5:0]  SH_FULL     = 6'h20;
  localparam logic [5:0]  SH_IMM_LMAX = 6'h1F;
  localparam logic [5:0]  SH_IMM_RMAX = 6'h20;
  localparam logic [5:0]  SH_IMM_MIN  = 6'h01;
  localparam logic [31:0] PC_ALIGN    = 32'hFFFF_FFFC;
  localparam logic [31:0] BR_ALIGN    = 32'hFFFF_FFFE;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [4:0] {
    OP_ADD   = 5'h00, OP_ADC  = 5'h01, OP_SUB = 5'h02,
    OP_SBC   = 5'h03, OP_RSB  = 5'h04, OP_WIDE_IMMEDIATE_ADD = 5'h05,
    OP_WIDE_IMMEDIATE_DIFFERENCE  = 5'h06, OP_AND  = 5'h07, OP_ORR = 5'h08,
    OP_EOR   = 5'h09, OP_BIC  = 5'h0A, OP_ORN = 5'h0B,
    OP_ASR   = 5'h0C, OP_LSL  = 5'h0D, OP_LSR = 5'h0E,
    OP_ROR   = 5'h0F, OP_RRX  = 5'h10, OP_CLZ = 5'h11,
    OP_CMP   = 5'h12, OP_CMN  = 5'h13
  } alu_op_e;

  typedef enum logic [2:0] {
    SK_LSL = 3'h0, SK_LSR = 3'h1, SK_ASR = 3'h2,
    SK_ROR = 3'h3, SK_RRX = 3'h4
  } shift_kind_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    alu_op_e              op;
    logic [DATA_W-1:0]    rn;        // first_operand_reg value
    logic                 rn_is_pc;
    logic                 rd_is_pc;
    logic [DATA_W-1:0]    op2;       // flexible_operand, pre-shifted
    logic                 op2_carry; // carry from operand shifter
    logic                 op2_carry_vld;
    logic                 use_twelve_bit_immediate;
    logic [TWELVE_BIT_IMMEDIATE_W-1:0]   twelve_bit_immediate;     // twelve_bit_immediate
    logic [DATA_W-1:0]    rm;        // shifted_source_reg value
    logic [DATA_W-1:0]    rs;        // shift_amount_reg value
    logic                 use_shimm;
    logic [SHIMM_W-1:0]   shimm;
    logic                 set_flags;
  } alu_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic              wr_en;
    logic              branch;
  } alu_rsp_s;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } alu_flags_s;

  localparam alu_flags_s FLAGS_RST = 4'h0;

endpackage

// ===== src/alu_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module alu_shifter
  import alu_pkg::*;
(
  // Operand and control
  input  wire logic [DATA_W-1:0] i_val,
  input  wire logic [AMT_W-1:0]  i_amt,
  input  wire shift_kind_e       i_kind,
  input  wire logic              i_cin,
  // Result
  output logic      [DATA_W-1:0] o_res,
  output logic                   o_cout
);

  // ****************************************
  // Barrel shift with carry out
  // ****************************************
  logic [DATA_W:0] t;
  logic [5:0]      amt_c;
  logic [4:0]      r;

  // Amounts past a full word give zero result and zero carry for LSL and LSR and saturate for ASR; ROR takes only the low five bits
  always_comb begin
    t      = '0;
    amt_c  = (i_amt > AMT_W'(SH_FULL)) ? SH_FULL : i_amt[5:0];
    r      = i_amt[4:0];
    o_res  = i_val;
    o_cout = i_cin;
    case (i_kind)
      SK_LSL: if (i_amt != '0) begin
        t      = {1'b0, i_val} << amt_c;
        o_res  = (i_amt > AMT_W'(SH_FULL)) ? '0 : t[MSB:0];
        o_cout = (i_amt > AMT_W'(SH_FULL)) ? 1'b0 : t[DATA_W];
      end
      SK_LSR: if (i_amt != '0) begin
        t      = {i_val, 1'b0} >> amt_c;
        o_res  = (i_amt > AMT_W'(SH_FULL)) ? '0 : t[DATA_W:1];
        o_cout = (i_amt > AMT_W'(SH_FULL)) ? 1'b0 : t[0];
      end
      SK_ASR: if (i_amt != '0) begin
        t      = $unsigned($signed({i_val, 1'b0}) >>> amt_c);
        o_res  = t[DATA_W:1];
        o_cout = t[0];
      end
      SK_ROR: if (i_amt != '0) begin
        o_res  = (i_val >> r) | (i_val << (6'(DATA_W) - {1'b0, r}));
        o_cout = o_res[MSB];
      end
      SK_RRX: begin
        o_res  = {i_cin, i_val[MSB:1]};
        o_cout = i_val[0];
      end
      default: begin
        o_res  = i_val;
        o_cout = i_cin;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== src/alu_clz.sv
`timescale 1ns/1ps
`default_nettype none
module alu_clz
  import alu_pkg::*;
(
  // Source word
  input  wire logic [DATA_W-1:0] i_val,
  // Count of leading zeros
  output logic      [CLZ_W-1:0]  o_cnt
);

  // ****************************************
  // Priority scan from the top bit
  // ****************************************
  function automatic logic [CLZ_W-1:0] lead_zeros(
    input logic [DATA_W-1:0] v
  );
    logic [CLZ_W-1:0] n;
    logic             hit;
    n   = CLZ_W'(DATA_W);
    hit = 1'b0;
    for (int i = MSB; i >= 0; i--) begin
      if (v[i] && !hit) begin
        n   = CLZ_W'(MSB - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // All zero gives 32, top bit set gives 0
  assign o_cnt = lead_zeros(i_val);

endmodule
`default_nettype wire

// ===== src/alu_core.sv
`timescale 1ns/1ps
`default_nettype none
module alu_core
  import alu_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_srst,
  // Request from decoder
  input  wire logic  i_valid,
  input  wire alu_req_s i_req,
  // Answer to register file
  output logic       o_valid,
  output alu_rsp_s   o_rsp,
  output logic       o_reject,
  // Condition flags
  output alu_flags_s o_flags
);

  // ****************************************
  // Arithmetic helper
  // ****************************************
  // Returns {overflow, carry, sum} of x + y + cin
  function automatic logic [DATA_W+1:0] add3(
    input logic [DATA_W-1:0] x,
    input logic [DATA_W-1:0] y,
    input logic              cin
  );
    logic [DATA_W:0] s;
    logic            v;
    s = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, cin};
    v = (x[MSB] == y[MSB]) && (s[MSB] != x[MSB]);
    return {v, s};
  endfunction

  // ****************************************
  // Operand preparation
  // ****************************************
  alu_flags_s        flags_ff;
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic [DATA_W-1:0] imm_ext;

  // Pc base is word aligned before any add or subtract
  assign opa = i_req.rn_is_pc ? (i_req.rn & PC_ALIGN)
                              : i_req.rn;
  assign imm_ext = {{(DATA_W-TWELVE_BIT_IMMEDIATE_W){1'b0}}, i_req.twelve_bit_immediate};

  // Immediate form chosen for add/subtract and the wide forms
  always_comb begin
    opb = i_req.op2;
    case (i_req.op)
      OP_WIDE_IMMEDIATE_ADD, OP_WIDE_IMMEDIATE_DIFFERENCE: opb = imm_ext;
      OP_ADD, OP_SUB:
        opb = i_req.use_twelve_bit_immediate ? imm_ext : i_req.op2;
      default: opb = i_req.op2;
    endcase
  end

  // ****************************************
  // Adder
  // ****************************************
  logic [DATA_W-1:0] ax;
  logic [DATA_W-1:0] ay;
  logic              acin;
  logic [DATA_W+1:0] asum;

  // One adder serves every arithmetic form via operand steering
  always_comb begin
    ax   = opa;
    ay   = opb;
    acin = 1'b0;
    case (i_req.op)
      OP_ADD, OP_WIDE_IMMEDIATE_ADD, OP_CMN: begin
        ay   = opb;
        acin = 1'b0;
      end
      OP_ADC: begin
        ay   = opb;
        acin = flags_ff.c;
      end
      OP_SUB, OP_WIDE_IMMEDIATE_DIFFERENCE, OP_CMP: begin
        ay   = ~opb;
        acin = 1'b1;
      end
      OP_SBC: begin
        ay   = ~opb;
        acin = flags_ff.c;
      end
      OP_RSB: begin
        ax   = opb;
        ay   = ~opa;
        acin = 1'b1;
      end
      default: begin
        ax   = opa;
        ay   = opb;
        acin = 1'b0;
      end
    endcase
  end

  assign asum = add3(ax, ay, acin);

  // ****************************************
  // Shifter and leading zero counter
  // ****************************************
  shift_kind_e       skind;
  logic [AMT_W-1:0]  samt;
  logic [DATA_W-1:0] sres;
  logic              scarry;
  logic [CLZ_W-1:0]  zcnt;
  logic              shimm_bad;

  // Register amounts keep only the low byte
  always_comb begin
    samt = i_req.use_shimm ? AMT_W'(i_req.shimm)
                           : i_req.rs[AMT_W-1:0];
    case (i_req.op)
      OP_ASR:  skind = SK_ASR;
      OP_LSL:  skind = SK_LSL;
      OP_LSR:  skind = SK_LSR;
      OP_ROR:  skind = SK_ROR;
      OP_RRX:  skind = SK_RRX;
      default: skind = SK_LSL;
    endcase
  end

  // Immediate shift limits differ per kind
  always_comb begin
    shimm_bad = 1'b0;
    if (i_req.use_shimm) begin
      case (i_req.op)
        OP_ASR, OP_LSR: shimm_bad = (i_req.shimm < SH_IMM_MIN) ||
                                    (i_req.shimm > SH_IMM_RMAX);
        OP_LSL:         shimm_bad = (i_req.shimm > SH_IMM_LMAX);
        OP_ROR:         shimm_bad = (i_req.shimm < SH_IMM_MIN) ||
                                    (i_req.shimm > SH_IMM_LMAX);
        default:        shimm_bad = 1'b0;
      endcase
    end
  end

  // Source is only read, never written back
  alu_shifter u_shifter (
    .i_val  (i_req.rm),
    .i_amt  (samt),
    .i_kind (skind),
    .i_cin  (flags_ff.c),
    .o_res  (sres),
    .o_cout (scarry)
  );

  alu_clz u_clz (
    .i_val (i_req.rm),
    .o_cnt (zcnt)
  );

  // ****************************************
  // Result and flag selection
  // ****************************************
  logic [DATA_W-1:0] res;
  logic              wr;
  logic              arith;
  logic              logic_op;
  logic              shift_op;

  always_comb begin
    res      = '0;
    wr       = 1'b1;
    arith    = 1'b0;
    logic_op = 1'b0;
    shift_op = 1'b0;
    case (i_req.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC,
      OP_RSB, OP_WIDE_IMMEDIATE_ADD, OP_WIDE_IMMEDIATE_DIFFERENCE: begin
        res   = asum[MSB:0];
        arith = 1'b1;
      end
      OP_CMP, OP_CMN: begin
        res   = asum[MSB:0];
        arith = 1'b1;
        wr    = 1'b0;
      end
      OP_AND: begin
        res      = opa & opb;
        logic_op = 1'b1;
      end
      OP_ORR: begin
        res      = opa | opb;
        logic_op = 1'b1;
      end
      OP_EOR: begin
        res      = opa ^ opb;
        logic_op = 1'b1;
      end
      OP_BIC: begin
        res      = opa & ~opb;
        logic_op = 1'b1;
      end
      OP_ORN: begin
        res      = opa | ~opb;
        logic_op = 1'b1;
      end
      OP_ASR, OP_LSL, OP_LSR, OP_ROR, OP_RRX: begin
        res      = sres;
        shift_op = 1'b1;
      end
      OP_CLZ: res = DATA_W'(zcnt);
      default: wr = 1'b0;
    endcase
  end

  // ****************************************
  // Next flag value
  // ****************************************
  alu_flags_s nxt_flags;
  logic       fl_en;

  // Out-of-range immediate shifts are refused; flags and destination stay, only o_rsp.result still loads
  assign fl_en = i_valid && !shimm_bad &&
                 (i_req.set_flags || i_req.op == OP_CMP ||
                  i_req.op == OP_CMN);

  always_comb begin
    nxt_flags = flags_ff;
    if (arith || logic_op || shift_op) begin
      nxt_flags.n = res[MSB];
      nxt_flags.z = (res == '0);
    end
    if (arith) begin
      nxt_flags.c = asum[DATA_W];
      nxt_flags.v = asum[DATA_W+1];
    end
    if (logic_op && i_req.op2_carry_vld)
      nxt_flags.c = i_req.op2_carry;
    if (shift_op)
      nxt_flags.c = scarry;
    // Leading zero count leaves every flag as it was
    if (i_req.op == OP_CLZ)
      nxt_flags = flags_ff;
  end

  // ****************************************
  // Flag register
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      flags_ff <= FLAGS_RST;
    end else if (fl_en) begin
      flags_ff <= nxt_flags;
    end
  end

  assign o_flags = flags_ff;

  // ****************************************
  // Answer registers
  // ****************************************
  logic pc_branch;

  // Any register-form add into pc is a branch, whatever the base; bit 0 of a branch target never reaches pc
  assign pc_branch = (i_req.op == OP_ADD) && i_req.rd_is_pc &&
                     !i_req.use_twelve_bit_immediate;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_valid  <= 1'b0;
      o_reject <= 1'b0;
      o_rsp    <= '0;
    end else begin
      o_valid  <= i_valid && !shimm_bad;
      o_reject <= i_valid && shimm_bad;
      if (i_valid) begin
        o_rsp.result <= pc_branch ? (res & BR_ALIGN) : res;
        o_rsp.wr_en  <= wr && !shimm_bad;
        o_rsp.branch <= pc_branch && !shimm_bad;
      end else begin
        o_rsp.wr_en  <= 1'b0;
        o_rsp.branch <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
module regfile_model
  import alu_pkg::*;
(
  // Clock
  input  wire logic     i_clk_sys,
  // Answer from datapath
  input  wire logic     i_valid,
  input  wire alu_rsp_s i_rsp,
  // Last value written back
  output logic [31:0]   o_dest
);
  logic [31:0] dest_ff;

  // Only the destination takes a result; sources are never written
  always_ff @(posedge i_clk_sys) begin
    if (i_valid && i_rsp.wr_en) begin
      dest_ff <= i_rsp.result;
    end
  end

  assign o_dest = dest_ff;
endmodule
`default_nettype wire

// ===== sim/alu_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module alu_core_chk
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  // Request
  input wire logic       i_valid,
  input wire alu_req_s   i_req,
  // Answer
  input wire logic       o_valid,
  input wire alu_rsp_s   o_rsp,
  input wire logic       o_reject,
  input wire alu_flags_s o_flags
);
  // ****
  // Timing and result checks
  // ****
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  a_one_answer: assert property (i_valid |-> ##1 (o_valid ^ o_reject))
    else $error("request not answered");
  a_no_stray: assert property (!i_valid |=> !o_valid && !o_rsp.wr_en)
    else $error("answer without request");
  a_clz_flags: assert property (i_valid && i_req.op == OP_CLZ |=>
    $stable(o_flags)) else $error("count changed flags");
  a_cmp_nowrite: assert property (i_valid &&
    i_req.op inside {OP_CMP, OP_CMN} |=> o_valid && !o_rsp.wr_en)
    else $error("compare wrote result");
  a_nz_flags: assert property (i_valid && i_req.set_flags &&
    i_req.op inside {[OP_ADD:OP_WIDE_IMMEDIATE_DIFFERENCE]} |=> o_flags.n == o_rsp.result[31]
    && o_flags.z == (o_rsp.result == 32'h0)) else $error("n or z wrong");
  a_add_sum: assert property (i_valid && i_req.op == OP_ADD &&
    !i_req.use_twelve_bit_immediate && !i_req.rn_is_pc && !i_req.rd_is_pc |=>
    o_rsp.result == $past(i_req.rn) + $past(i_req.op2)) else $error("sum");
  a_logic_v: assert property (i_valid && i_req.set_flags &&
    i_req.op inside {[OP_AND:OP_ORN]} |=> o_flags.v == $past(o_flags.v))
    else $error("logic op changed v");
  a_rrx_bits: assert property (i_valid && i_req.op == OP_RRX |=>
    o_rsp.result == ({$past(o_flags.c), 31'h0} | ($past(i_req.rm) >> 1)))
    else $error("rotate through carry");
  a_branch_even: assert property (o_rsp.branch |->
    o_valid && !o_rsp.result[0]) else $error("odd branch target");
  a_lsl_refuse: assert property (i_valid && i_req.use_shimm &&
    i_req.op == OP_LSL && i_req.shimm > SH_IMM_LMAX |=> o_reject)
    else $error("bad shift accepted");

  // Main scenarios reached
  c_adc: cover property (i_valid && i_req.op == OP_ADC ##1 o_valid);
  c_reject: cover property (o_reject);
  c_branch: cover property (o_rsp.branch);
endmodule

bind alu_core alu_core_chk alu_core_chk_i (.i_clk_sys(i_clk_sys),
  .i_srst(i_srst), .i_valid(i_valid), .i_req(i_req), .o_valid(o_valid),
  .o_rsp(o_rsp), .o_reject(o_reject), .o_flags(o_flags));
`default_nettype wire

// ===== sim/integer_alu_data_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none
module integer_alu_data_ops_tb
  import alu_pkg::*;
;
  logic        i_clk_sys = 1'b0;
  logic        i_srst    = 1'b1;
  logic        i_valid   = 1'b0;
  alu_req_s    i_req     = '0;
  logic        o_valid;
  logic        o_reject;
  alu_rsp_s    o_rsp;
  alu_flags_s  o_flags;
  alu_flags_s  mf;
  logic [31:0] dest, er, lw;
  logic        ew, ej, eb, pend;
  int          errors = 0;
  int          total_checks = 0;
  logic [31:0] sa [8] = '{0, 1, 31, 32, 33, 64, 255, 32'h120};
  logic [5:0]  sh [5] = '{0, 1, 31, 32, 33};

  // 40 MHz clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  alu_core alu_core_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_valid(i_valid), .i_req(i_req), .o_valid(o_valid),
    .o_rsp(o_rsp), .o_reject(o_reject), .o_flags(o_flags));
  regfile_model regfile_model_i (.i_clk_sys(i_clk_sys),
    .i_valid(o_valid), .i_rsp(o_rsp), .o_dest(dest));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Sum with carry out and signed overflow
  function automatic logic [33:0] ad(input logic [31:0] x, y, input logic ci);
    logic [32:0] t;
    t = x + y + ci;
    return {t[32], x[31] == y[31] && t[31] != x[31], t[31:0]};
  endfunction

  function automatic alu_req_s rq(input alu_op_e o, input logic [31:0] n,
                                  input logic [31:0] m, s, input logic f);
    alu_req_s r;
    r = '0;
    r.op = o;
    r.rn = n;
    r.op2 = m;
    r.rm = m;
    r.rs = s;
    r.set_flags = f;
    return r;
  endfunction

  // Reference datapath; model flags follow issue order
  task automatic model(input alu_req_s r);
    logic [31:0] a, b, s;
    logic [64:0] w;
    logic [32:0] x;
    logic [63:0] y;
    logic [7:0]  m;
    logic        c, v, sk;
    a = r.rn_is_pc ? r.rn & PC_ALIGN : r.rn;
    b = r.use_twelve_bit_immediate ? 32'(r.twelve_bit_immediate) : r.op2;
    m = r.use_shimm ? 8'(r.shimm) : r.rs[7:0];
    c = mf.c;
    v = mf.v;
    ej = 1'b0;
    case (r.op)
      OP_ADD, OP_WIDE_IMMEDIATE_ADD, OP_CMN: {c, v, s} = ad(a, b, 1'b0);
      OP_ADC: {c, v, s} = ad(a, r.op2, mf.c);
      OP_SUB, OP_WIDE_IMMEDIATE_DIFFERENCE, OP_CMP: {c, v, s} = ad(a, ~b, 1'b1);
      OP_SBC: {c, v, s} = ad(a, ~r.op2, mf.c);
      OP_RSB: {c, v, s} = ad(r.op2, ~a, 1'b1);
      OP_AND: s = r.rn & r.op2;
      OP_ORR: s = r.rn | r.op2;
      OP_EOR: s = r.rn ^ r.op2;
      OP_BIC: s = r.rn & ~r.op2;
      OP_ORN: s = r.rn | ~r.op2;
      OP_LSL: begin
        w = {33'h0, r.rm} << m;
        {c, s} = w[32:0];
        ej = r.shimm > SH_IMM_LMAX;
      end
      OP_LSR, OP_ASR: begin
        // Kept apart so the arithmetic shift stays signed
        if (r.op == OP_ASR)
          x = $unsigned($signed({r.rm, 1'b0}) >>> m);
        else
          x = {r.rm, 1'b0} >> m;
        {s, c} = x;
        ej = r.shimm < SH_IMM_MIN || r.shimm > SH_IMM_RMAX;
      end
      OP_ROR: begin
        y = {r.rm, r.rm} >> m[4:0];
        s = y[31:0];
        c = s[31];
        ej = r.shimm < SH_IMM_MIN || r.shimm > SH_IMM_LMAX;
      end
      OP_RRX: {s, c} = {mf.c, r.rm};
      default: begin
        s = 32'h20;
        for (int i = 0; i < 32; i++)
          if (r.rm[i]) s = 32'(31 - i);
      end
    endcase
    sk = r.op inside {[OP_ASR:OP_ROR]};
    if (sk && m == 8'h0) {s, c} = {r.rm, mf.c};
    ej = ej && r.use_shimm;
    if (r.op inside {[OP_AND:OP_ORN]} && r.op2_carry_vld) c = r.op2_carry;
    eb = r.op == OP_ADD && r.rd_is_pc && !r.use_twelve_bit_immediate;
    if (eb) s[0] = 1'b0;
    if (!ej && r.op != OP_CLZ && (r.set_flags || r.op inside {OP_CMP, OP_CMN}))
      mf = {s[31], s == 32'h0, c, v};
    ew = !ej && !(r.op inside {OP_CMP, OP_CMN});
    if (ew) lw = s;
    er = s;
  endtask

  // One cycle: drive, then check the answer to last cycle's request
  task automatic step(input logic v, input alu_req_s r);
    @(posedge i_clk_sys);
    i_valid <= v;
    i_req   <= r;
    @(negedge i_clk_sys);
    if (pend) begin
      chk({o_valid, o_reject}, {!ej, ej});
      chk({o_rsp.wr_en, o_rsp.branch}, {ew, eb});
      if (ew) chk(o_rsp.result, er);
      chk(o_flags, mf);
    end else begin
      chk({o_valid, o_reject}, 2'h0);
    end
    if (v) model(r);
    pend = v;
  endtask

  task automatic rst(input int n);
    @(posedge i_clk_sys);
    i_srst  <= 1'b1;
    i_valid <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(negedge i_clk_sys);
    chk({o_valid, o_reject, o_rsp.wr_en, o_rsp.branch, o_flags}, 32'h0);
    chk(o_rsp.result, 32'h0);
    mf = '0;
    pend = 1'b0;
  endtask

  initial begin
    alu_req_s r;
    {ew, ej, eb, er, lw} = '0;
    void'($urandom(93602));
    rst(16);
    // Carry and borrow chains, back to back
    step(1, rq(OP_ADD, 32'hFFFF_FFFF, 32'h1, 0, 1));
    step(1, rq(OP_ADC, 32'h7FFF_FFFF, 32'h0, 0, 1));
    step(1, rq(OP_SUB, 32'h0, 32'h1, 0, 1));
    step(1, rq(OP_SBC, 32'h5, 32'h2, 0, 1));
    step(1, rq(OP_RSB, 32'h1, 32'h8000_0000, 0, 1));
    step(1, rq(OP_CMP, 32'h3, 32'h3, 0, 0));
    step(1, rq(OP_CLZ, 32'h0, 32'h0, 0, 1));
    step(1, rq(OP_CLZ, 32'h0, 32'h8000_0000, 0, 1));
    step(1, rq(OP_CMN, 32'hFFFF_FFFF, 32'h1, 0, 0));
    step(1, rq(OP_RRX, 32'h0, 32'h3, 0, 1));
    // Register amounts around the word width, then immediates
    for (int i = 0; i < 32; i++)
      step(1, rq(alu_op_e'(5'(OP_ASR + i % 4)), 0, 32'hC000_0005, sa[i / 4], 1));
    for (int i = 0; i < 20; i++) begin
      r = rq(alu_op_e'(5'(OP_ASR + i % 4)), 0, 32'h9000_0003, 0, 1);
      r.use_shimm = 1'b1;
      r.shimm = sh[i / 4];
      step(1, r);
    end
    // Computed branch from a word-aligned base
    r = rq(OP_ADD, 32'h0000_1006, 32'h0000_0011, 0, 0);
    r.rn_is_pc = 1'b1;
    r.rd_is_pc = 1'b1;
    step(1, r);
    rst(3);
    for (int k = 0; k < 600; k++) begin
      r.op = alu_op_e'(5'($urandom_range(19)));
      {r.rn, r.op2, r.rm, r.rs} = {$urandom, $urandom, $urandom, $urandom};
      if (k % 3 == 0) r.rs[7:0] = 8'($urandom_range(40));
      r.twelve_bit_immediate = 12'($urandom);
      r.shimm = 6'($urandom_range(34));
      {r.op2_carry, r.op2_carry_vld, r.set_flags} = 3'($urandom);
      r.use_twelve_bit_immediate = r.op inside {OP_WIDE_IMMEDIATE_ADD, OP_WIDE_IMMEDIATE_DIFFERENCE} ||
                    (r.op inside {OP_ADD, OP_SUB} && $urandom_range(1) == 1);
      r.use_shimm = r.op inside {[OP_ASR:OP_ROR]} && $urandom_range(1) == 1;
      // Counter base only unflagged, with a constant
      r.rn_is_pc = r.use_twelve_bit_immediate && !r.set_flags && $urandom_range(3) == 0;
      // No stack or counter destination in random traffic
      r.rd_is_pc = 1'b0;
      step($urandom_range(3) != 0, r);
    end
    step(0, r);
    step(0, r);
    chk(dest, lw);
    tally_and_finish();
  end
endmodule
`default_nettype wire
